// ### src/sfcr_regs.sv
/*
 servo filter command registers: serial command receiver, three write-only
 16-bit registers, and the decoded controls for the servo filter datapath.
 assumes the host serial clock, data and latch are asynchronous pins and
 that clock and latch are slow against core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Summary of operation
// - skip bit plus gain-up2 selects K30 coefficient
// - hold skip plus gain-up2 selects K46
// - sled filter fed from track second stage
// - hold filter fed from track second stage
// - corrections gated per enable and sled-disable
// - eight quasi-double accuracy stage enables
// - lock pin output or external input
// - cross-count pin output or external input
// - mirror, defect, focus-ok internal or external
// - undivided clock overrides all divide sources
// - divide two, then four, then pin
// - amplitude extend gives 1/8 to focus and track
// - clear bits zero selected data words
// - shock gain bit forces focus gain normal
// - agc half frequency halves sine rate
// - focus search slope quarter
// - shock pin driven with detected shock
// - shock comparator trips at 1/16 full
// - slow filters 345 Hz, fast 88.2 kHz
// ------------------------------------------------------------
module sfcr_regs #(
    parameter int SHOCK_BITS = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_clk,
    input wire logic cmd_data,
    input wire logic cmd_latch,
    input wire logic crystal_select_pin,
    input wire logic track_gain_up2,
    input wire logic shock_active,
    input wire logic [SHOCK_BITS-1:0] shock_level,
    input wire logic lock_int,
    input wire logic cross_count_int,
    input wire logic mirror_int,
    input wire logic defect_int,
    input wire logic focus_ok_int,
    input wire logic lock_pin_i,
    input wire logic cross_count_pin_i,
    input wire logic mirror_pin_i,
    input wire logic defect_pin_i,
    input wire logic focus_ok_pin_i,
    input wire logic shock_pin_i,
    output logic lock_pin_o,
    output logic lock_pin_oe,
    output logic cross_count_pin_o,
    output logic cross_count_pin_oe,
    output logic shock_pin_o,
    output logic shock_pin_oe,
    output logic lock_signal,
    output logic cross_count_signal,
    output logic mirror_signal,
    output logic defect_signal,
    output logic focus_ok_signal,
    output sfcr_pkg::sfcr_route_t route,
    output sfcr_pkg::sfcr_misc_t misc,
    output logic [7:0] precise_stages,
    output sfcr_pkg::sfcr_div_t servo_clock_div,
    output logic shock_detected,
    output logic slow_fs_tick,
    output logic fast_fs_tick
);
    // below 5 bits there is no room for the 1/16 trip level
    if (SHOCK_BITS < 5 || SHOCK_BITS > 32) begin
        $error("shock level width unsupported");
    end
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 10'h000;
            sync2_q <= 10'h000;
        end else begin
            sync1_q <= {cmd_clk, cmd_data, cmd_latch, lock_pin_i, cross_count_pin_i,
                        mirror_pin_i, defect_pin_i, focus_ok_pin_i, shock_pin_i, crystal_select_pin};
            sync2_q <= sync1_q;
        end
    end
    logic s_clk, s_data, s_latch, s_lock, s_cross, s_mirror_signal, s_defect_signal, s_fok, s_xtal;
    assign {s_clk, s_data, s_latch, s_lock, s_cross, s_mirror_signal, s_defect_signal, s_fok} = sync2_q[9:2];
    assign s_xtal = sync2_q[0];
    // ------------------------------------------------------------
    // serial command receiver
    // ------------------------------------------------------------
    logic clk_prev_q, latch_prev_q;
    logic [23:0] shift_q;
    logic [5:0] count_q;
    logic bit_take, word_done;
    assign bit_take = s_clk && !clk_prev_q;
    // latched on the falling edge of the strobe
    assign word_done = latch_prev_q && !s_latch;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_prev_q <= 1'b0;
            latch_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= s_clk;
            latch_prev_q <= s_latch;
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shift_q <= 24'h000000;
            count_q <= 6'h00;
        end else if (word_done) begin
            count_q <= 6'h00;
        end else if (bit_take) begin
            shift_q <= {shift_q[22:0], s_data};
            if (count_q != 6'h3f) begin
                count_q <= count_q + 6'h01;
            end
        end
    end
    // short or long words are dropped: only exact frames load
    logic load_ok;
    assign load_ok = word_done && (count_q == 6'(sfcr_pkg::SFCR_WORD_BITS));
    // ------------------------------------------------------------
    // command registers
    // ------------------------------------------------------------
    logic [15:0] routing_q, accuracy_q, clock_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            routing_q <= sfcr_pkg::SFCR_RESET_VALUE;
            accuracy_q <= sfcr_pkg::SFCR_RESET_VALUE;
            clock_q <= sfcr_pkg::SFCR_RESET_VALUE;
        end else if (load_ok) begin
            unique case (shift_q[23:16])
                sfcr_pkg::SFCR_ADDR_ROUTING: routing_q <= shift_q[15:0] & sfcr_pkg::SFCR_MASK_ROUTING;
                sfcr_pkg::SFCR_ADDR_ACCURACY: accuracy_q <= shift_q[15:0] & sfcr_pkg::SFCR_MASK_ACCURACY;
                sfcr_pkg::SFCR_ADDR_CLOCK: clock_q <= shift_q[15:0] & sfcr_pkg::SFCR_MASK_CLOCK;
                default: ;
            endcase
        end
    end
    // ------------------------------------------------------------
    // filter routing and corrections
    // ------------------------------------------------------------
    logic [2:0] tlc;
    assign tlc = {accuracy_q[6], 2'b11}; // zero-level, ref enables held on, centre from register
    always_comb begin
        route.sel_k30 = routing_q[sfcr_pkg::SFCR_SLED_SKIP] && track_gain_up2;
        route.sel_k46 = routing_q[sfcr_pkg::SFCR_HOLD_SKIP] && track_gain_up2;
        route.sled_from_track = routing_q[sfcr_pkg::SFCR_SLED_SEL];
        route.hold_from_track = routing_q[sfcr_pkg::SFCR_HOLD_SEL];
        route.track_correct = tlc;
        route.sled_correct = tlc & ~routing_q[sfcr_pkg::SFCR_SLED_DIS_LO +: 3];
    end
    assign precise_stages = accuracy_q[sfcr_pkg::SFCR_PRECISE_LO +: 8];
    // ------------------------------------------------------------
    // pin direction and detect source
    // ------------------------------------------------------------
    logic lock_ext, cross_ext, det_ext, mirror_signal_ext;
    assign lock_ext = accuracy_q[sfcr_pkg::SFCR_LOCK_SEL];
    assign cross_ext = accuracy_q[sfcr_pkg::SFCR_CROSS_SEL];
    assign det_ext = accuracy_q[sfcr_pkg::SFCR_EXT_DET];
    assign mirror_signal_ext = accuracy_q[sfcr_pkg::SFCR_MIRROR_SEL];
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lock_pin_o <= 1'b0;
            cross_count_pin_o <= 1'b0;
            shock_pin_o <= 1'b0;
        end else begin
            lock_pin_o <= lock_int;
            cross_count_pin_o <= cross_count_int;
            shock_pin_o <= shock_detected;
        end
    end
    assign lock_pin_oe = !lock_ext;
    assign cross_count_pin_oe = !cross_ext;
    assign shock_pin_oe = clock_q[sfcr_pkg::SFCR_SHOCK_OUT];
    assign lock_signal = lock_ext ? s_lock : lock_int;
    assign cross_count_signal = cross_ext ? s_cross : cross_count_int;
    // mirror-only external when just the mirror bit is set
    assign mirror_signal = (det_ext || mirror_signal_ext) ? s_mirror_signal : mirror_int;
    assign defect_signal = det_ext ? s_defect_signal : defect_int;
    assign focus_ok_signal = det_ext ? s_fok : focus_ok_int;
    // ------------------------------------------------------------
    // clock division, amplitude, clears, anti-shock
    // ------------------------------------------------------------
    always_comb begin
        if (accuracy_q[sfcr_pkg::SFCR_UNDIV]) begin
            servo_clock_div = sfcr_pkg::SFCR_DIV_1;
        end else if (clock_q[sfcr_pkg::SFCR_DIV_TWO]) begin
            servo_clock_div = sfcr_pkg::SFCR_DIV_2;
        end else if (clock_q[sfcr_pkg::SFCR_DIV_FOUR]) begin
            servo_clock_div = sfcr_pkg::SFCR_DIV_4;
        end else begin
            servo_clock_div = s_xtal ? sfcr_pkg::SFCR_DIV_1 : sfcr_pkg::SFCR_DIV_2;
        end
    end
    // amplitude as right shift of full scale; default codes 5/4/3 approximate
    logic focus_amp_bit, track_amp_bit;
    logic [1:0] amp_code;
    assign focus_amp_bit = 1'b1;
    assign track_amp_bit = 1'b1;
    assign amp_code = {focus_amp_bit, track_amp_bit};
    always_comb begin
        misc.clr_words_08_0a = clock_q[sfcr_pkg::SFCR_CLR_0A];
        misc.clr_sled_words = clock_q[sfcr_pkg::SFCR_CLR_SLED]
                            || (clock_q[sfcr_pkg::SFCR_CLR_UNLK] && !lock_signal);
        misc.force_gain_normal = clock_q[sfcr_pkg::SFCR_SHOCK_GAIN] && shock_active
                               && shock_detected;
        misc.agc_half_frequency = clock_q[sfcr_pkg::SFCR_AGC_HALF];
        misc.focus_search_slope_quarter = clock_q[sfcr_pkg::SFCR_SLOPE_QTR];
        if (clock_q[sfcr_pkg::SFCR_AMP_EXT]) begin
            misc.fe_amp_shift = 3'(6 - amp_code);
            misc.te_amp_shift = 3'(6 - amp_code);
        end else begin
            misc.fe_amp_shift = focus_amp_bit ? 3'h4 : 3'h5;
            misc.te_amp_shift = track_amp_bit ? 3'h3 : 3'h4;
        end
    end
    // comparator at 1/16 of full signed magnitude
    logic [SHOCK_BITS-1:0] shock_mag;
    logic [SHOCK_BITS-1:0] shock_trip;
    assign shock_mag = shock_level[SHOCK_BITS-1] ? -shock_level : shock_level;
    assign shock_trip = (SHOCK_BITS)'(1) << (SHOCK_BITS - 5);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shock_detected <= 1'b0;
        end else if (fast_fs_tick) begin
            shock_detected <= shock_mag >= shock_trip;
        end
    end
    // ------------------------------------------------------------
    // filter sample rate enables
    // ------------------------------------------------------------
    logic [15:0] slow_cnt_q;
    logic [7:0] fast_cnt_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            slow_cnt_q <= 16'h0000;
            fast_cnt_q <= 8'h00;
        end else begin
            slow_cnt_q <= slow_fs_tick ? 16'h0000 : slow_cnt_q + 16'h0001;
            fast_cnt_q <= fast_fs_tick ? 8'h00 : fast_cnt_q + 8'h01;
        end
    end
    assign slow_fs_tick = slow_cnt_q == 16'(sfcr_pkg::SFCR_SLOW_CYC - 1);
    assign fast_fs_tick = fast_cnt_q == 8'(sfcr_pkg::SFCR_FAST_CYC - 1);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    k30_select_a: assert property (@(posedge core_clk) disable iff (rst)
        route.sel_k30 == (routing_q[14] && track_gain_up2)) else $error("k30 select wrong");
    k46_select_a: assert property (@(posedge core_clk) disable iff (rst)
        route.sel_k46 |-> track_gain_up2 && routing_q[12]) else $error("k46 select wrong");
    sled_correct_a: assert property (@(posedge core_clk) disable iff (rst)
        (route.sled_correct & ~route.track_correct) == 3'h0) else $error("sled corrected alone");
    lock_dir_a: assert property (@(posedge core_clk) disable iff (rst)
        lock_pin_oe != lock_ext) else $error("lock pin direction wrong");
    cross_dir_a: assert property (@(posedge core_clk) disable iff (rst)
        cross_ext |-> !cross_count_pin_oe) else $error("cross pin driven while external");
    undiv_wins_a: assert property (@(posedge core_clk) disable iff (rst)
        accuracy_q[0] |-> servo_clock_div == sfcr_pkg::SFCR_DIV_1) else $error("undivided clock lost");
    clear_sled_a: assert property (@(posedge core_clk) disable iff (rst)
        clock_q[9] |-> misc.clr_sled_words) else $error("sled clear missing");
    load_write_a: assert property (@(posedge core_clk) disable iff (rst)
        load_ok && shift_q[23:16] == 8'h3f |=> clock_q == ($past(shift_q[15:0]) & sfcr_pkg::SFCR_MASK_CLOCK))
        else $error("clock register not loaded");
    fast_rate_a: assert property (@(posedge core_clk) disable iff (rst)
        fast_fs_tick |=> !fast_fs_tick [*8]) else $error("fast tick too close");
    slow_rate_a: assert property (@(posedge core_clk) disable iff (rst)
        slow_fs_tick |=> !slow_fs_tick [*8]) else $error("slow tick too close");
    reset_clear_a: assert property (@(posedge core_clk)
        rst |=> (routing_q | accuracy_q | clock_q) == sfcr_pkg::SFCR_RESET_VALUE) else $error("register kept after reset");
    reserved_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        (routing_q & ~sfcr_pkg::SFCR_MASK_ROUTING) == 16'h0000
        && (accuracy_q & ~sfcr_pkg::SFCR_MASK_ACCURACY) == 16'h0000
        && (clock_q & ~sfcr_pkg::SFCR_MASK_CLOCK) == 16'h0000) else $error("reserved bit held");
    div_two_a: assert property (@(posedge core_clk) disable iff (rst)
        !accuracy_q[sfcr_pkg::SFCR_UNDIV] && clock_q[sfcr_pkg::SFCR_DIV_TWO] |-> servo_clock_div == sfcr_pkg::SFCR_DIV_2)
        else $error("divide by two lost");
    amp_ext_a: assert property (@(posedge core_clk) disable iff (rst)
        clock_q[sfcr_pkg::SFCR_AMP_EXT] |-> misc.fe_amp_shift == misc.te_amp_shift
        && misc.fe_amp_shift >= 3'h3 && misc.fe_amp_shift <= 3'h6) else $error("extended amplitude out of range");
    detect_int_a: assert property (@(posedge core_clk) disable iff (rst)
        !det_ext && !mirror_signal_ext |-> mirror_signal == mirror_int && defect_signal == defect_int
        && focus_ok_signal == focus_ok_int) else $error("detect source wrong");
    shock_force_a: assert property (@(posedge core_clk) disable iff (rst)
        clock_q[sfcr_pkg::SFCR_SHOCK_GAIN] && shock_active && shock_detected |-> misc.force_gain_normal)
        else $error("focus gain not forced");
    shock_pin_a: assert property (@(posedge core_clk) disable iff (rst)
        shock_pin_oe |-> shock_pin_o == $past(shock_detected)) else $error("shock pin lags detector");
    shock_trip_a: assert property (@(posedge core_clk) disable iff (rst)
        fast_fs_tick && shock_mag < shock_trip |=> !shock_detected) else $error("shock tripped below level");
    cover_load_c: cover property (@(posedge core_clk) disable iff (rst) load_ok);
    cover_k30_c: cover property (@(posedge core_clk) disable iff (rst) route.sel_k30);
    cover_shock_c: cover property (@(posedge core_clk) disable iff (rst) misc.force_gain_normal);
    cover_clear_c: cover property (@(posedge core_clk) disable iff (rst) misc.clr_sled_words);
    cover_div4_c: cover property (@(posedge core_clk) disable iff (rst) servo_clock_div == sfcr_pkg::SFCR_DIV_4);
endmodule
`default_nettype wire

// ### src/sfcr_pkg.sv
/*
 servo filter command register package: addresses, bit positions, reset values,
 carriers for the decoded controls.
 assumes a serial command word of 8-bit address and 16 data bits, msb first.
*/
package sfcr_pkg;
    // ------------------------------------------------------------
    // addresses and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SFCR_ADDR_ROUTING = 8'h3d;
    localparam logic [7:0] SFCR_ADDR_ACCURACY = 8'h3e;
    localparam logic [7:0] SFCR_ADDR_CLOCK = 8'h3f;
    localparam logic [15:0] SFCR_RESET_VALUE = 16'h0000;
    localparam int SFCR_WORD_BITS = 24;
    // writable bits per register, reserved positions masked
    localparam logic [15:0] SFCR_MASK_ROUTING = 16'hf700;
    localparam logic [15:0] SFCR_MASK_ACCURACY = 16'hffdf;
    localparam logic [15:0] SFCR_MASK_CLOCK = 16'h7772;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SFCR_SLED_SEL = 15;
    localparam int SFCR_SLED_SKIP = 14;
    localparam int SFCR_HOLD_SEL = 13;
    localparam int SFCR_HOLD_SKIP = 12;
    localparam int SFCR_SLED_DIS_LO = 8;
    localparam int SFCR_PRECISE_LO = 8;
    localparam int SFCR_LOCK_SEL = 4;
    localparam int SFCR_CROSS_SEL = 3;
    localparam int SFCR_EXT_DET = 2;
    localparam int SFCR_MIRROR_SEL = 1;
    localparam int SFCR_UNDIV = 0;
    localparam int SFCR_AMP_EXT = 14;
    localparam int SFCR_DIV_FOUR = 13;
    localparam int SFCR_DIV_TWO = 12;
    localparam int SFCR_CLR_0A = 10;
    localparam int SFCR_CLR_SLED = 9;
    localparam int SFCR_CLR_UNLK = 8;
    localparam int SFCR_SHOCK_GAIN = 6;
    localparam int SFCR_SLOPE_QTR = 5;
    localparam int SFCR_SHOCK_OUT = 4;
    localparam int SFCR_AGC_HALF = 1;
    // ------------------------------------------------------------
    // timing: 10 MHz core clock
    // ------------------------------------------------------------
    localparam int SFCR_CLK_HZ = 10_000_000;
    localparam int SFCR_SLOW_FS_HZ = 345;
    localparam int SFCR_FAST_FS_HZ = 88_200;
    localparam int SFCR_SLOW_CYC = SFCR_CLK_HZ / SFCR_SLOW_FS_HZ;
    localparam int SFCR_FAST_CYC = SFCR_CLK_HZ / SFCR_FAST_FS_HZ;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SFCR_DIV_PIN = 2'b00,
        SFCR_DIV_1 = 2'b01,
        SFCR_DIV_2 = 2'b10,
        SFCR_DIV_4 = 2'b11
    } sfcr_div_t;
    typedef struct packed {
        logic sel_k30;
        logic sel_k46;
        logic sled_from_track;
        logic hold_from_track;
        logic [2:0] track_correct;
        logic [2:0] sled_correct;
    } sfcr_route_t;
    typedef struct packed {
        logic clr_words_08_0a;
        logic clr_sled_words;
        logic force_gain_normal;
        logic agc_half_frequency;
        logic focus_search_slope_quarter;
        logic [2:0] fe_amp_shift;
        logic [2:0] te_amp_shift;
    } sfcr_misc_t;
endpackage

// ### dv/sfcr_host.sv
/*
 host side of the serial command pins: sends one word, msb first.
 assumes core_clk is the bench clock; pins change just after its rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module sfcr_host (
    input wire logic core_clk,
    output logic cmd_clk,
    output logic cmd_data,
    output logic cmd_latch
);
    initial begin
        cmd_clk = 1'b0;
        cmd_data = 1'b0;
        cmd_latch = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // ----------------------------------------
    // word transfer
    // ----------------------------------------
    // no coefficient words pass these pins: sign flip and boost msb duties stay idle
    // four cycles a phase, above the three the receiver needs
    task automatic send(input logic [23:0] w, input int n);
        cmd_latch <= 1'b1;
        tick(4);
        for (int i = 23; i > 23 - n; i--) begin
            cmd_data <= w[i];
            tick(4);
            cmd_clk <= 1'b1;
            tick(4);
            cmd_clk <= 1'b0;
        end
        tick(4);
        cmd_latch <= 1'b0;
        tick(4);
        cmd_data <= ~cmd_data;
        // sled clears held long enough before anything else
        if (w[23:16] == 8'h3f && w[9:8] != 2'b00) tick(500);
    endtask
endmodule
`default_nettype wire

// ### dv/servo_filter_command_regs_tb.sv
/*
 bench for the servo filter command registers, with a register model.
 assumes sfcr_host drives the serial pins; all other inputs come from here.
*/
`timescale 1ns/1ns
`default_nettype none
module servo_filter_command_regs_tb;
    logic core_clk, rst, cmd_clk, cmd_data, cmd_latch, crystal_select_pin, track_gain_up2;
    logic shock_active, lock_int, cross_count_int, mirror_int, defect_int, focus_ok_int;
    logic lock_pin_i, cross_count_pin_i, mirror_pin_i, defect_pin_i, focus_ok_pin_i, shock_pin_i;
    logic [15:0] shock_level;
    logic lock_pin_o, lock_pin_oe, cross_count_pin_o, cross_count_pin_oe, shock_pin_o, shock_pin_oe;
    logic lock_signal, cross_count_signal, mirror_signal, defect_signal, focus_ok_signal;
    logic shock_detected, slow_fs_tick, fast_fs_tick;
    logic [7:0] precise_stages;
    sfcr_pkg::sfcr_route_t route;
    sfcr_pkg::sfcr_misc_t misc;
    sfcr_pkg::sfcr_div_t servo_clock_div;
    logic [15:0] mr [3];
    logic [31:0] seed = 32'hdf4abe81;
    int failures = 0, tests_run = 0, fcnt = 0, scnt = 0, fper = 0, sper = 0;

    sfcr_host host (.core_clk, .cmd_clk, .cmd_data, .cmd_latch);
    sfcr_regs #(.SHOCK_BITS(16)) DUT (.core_clk, .rst, .cmd_clk, .cmd_data, .cmd_latch,
        .crystal_select_pin, .track_gain_up2, .shock_active, .shock_level, .lock_int,
        .cross_count_int, .mirror_int, .defect_int, .focus_ok_int, .lock_pin_i, .cross_count_pin_i,
        .mirror_pin_i, .defect_pin_i, .focus_ok_pin_i, .shock_pin_i, .lock_pin_o, .lock_pin_oe,
        .cross_count_pin_o, .cross_count_pin_oe, .shock_pin_o, .shock_pin_oe, .lock_signal,
        .cross_count_signal, .mirror_signal, .defect_signal, .focus_ok_signal, .route, .misc,
        .precise_stages, .servo_clock_div, .shock_detected, .slow_fs_tick, .fast_fs_tick);

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // sample spacing of the two filter rates
    // ----------------------------------------
    always @(posedge core_clk) begin
        fcnt <= fast_fs_tick ? 1 : fcnt + 1;
        scnt <= slow_fs_tick ? 1 : scnt + 1;
        if (fast_fs_tick) fper <= fcnt;
        if (slow_fs_tick) sper <= scnt;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rand_in();
        seed = lfsr(seed);
        {crystal_select_pin, track_gain_up2, lock_int, cross_count_int, mirror_int, defect_int,
            focus_ok_int, lock_pin_i, cross_count_pin_i, mirror_pin_i, defect_pin_i, focus_ok_pin_i,
            shock_pin_i} <= seed[12:0];
    endtask
    // ----------------------------------------
    // expected decode from the model
    // ----------------------------------------
    task automatic cmp();
        logic [15:0] a, b, c;
        logic ls;
        logic [2:0] tc;
        sfcr_pkg::sfcr_div_t dv;
        #1;
        a = mr[0];
        b = mr[1];
        c = mr[2];
        ls = b[4] ? lock_pin_i : lock_int;
        tc = {b[6], 2'b11};
        if (b[0]) dv = sfcr_pkg::SFCR_DIV_1;
        else if (c[12]) dv = sfcr_pkg::SFCR_DIV_2;
        else if (c[13]) dv = sfcr_pkg::SFCR_DIV_4;
        else dv = crystal_select_pin ? sfcr_pkg::SFCR_DIV_1 : sfcr_pkg::SFCR_DIV_2;
        chk("route", 16'(route), 16'({a[14] & track_gain_up2, a[12] & track_gain_up2, a[15], a[13],
            tc, tc & ~a[10:8]}));
        chk("stages", 16'(precise_stages), 16'(b[15:8]));
        chk("pins", 16'({lock_pin_oe, lock_signal, cross_count_pin_oe, cross_count_signal}),
            16'({~b[4], ls, ~b[3], b[3] ? cross_count_pin_i : cross_count_int}));
        chk("detect", 16'({mirror_signal, defect_signal, focus_ok_signal}), 16'(b[2] ?
            {mirror_pin_i, defect_pin_i, focus_ok_pin_i} : {b[1] ? mirror_pin_i : mirror_int,
            defect_int, focus_ok_int}));
        chk("div", 16'(servo_clock_div), 16'(dv));
        chk("pin drive", 16'({lock_pin_o, cross_count_pin_o}), 16'({lock_int, cross_count_int}));
        chk("misc", 16'({misc.clr_words_08_0a, misc.clr_sled_words, misc.agc_half_frequency,
            misc.focus_search_slope_quarter, shock_pin_oe}), 16'({c[10], c[9] | (c[8] & ~ls), c[1], c[5], c[4]}));
        chk("amp", 16'({misc.fe_amp_shift, misc.te_amp_shift}), c[14] ? 16'h001b : 16'h0023);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
        rand_in();
        host.send({a, d}, n);
        if (n == 24 && a == sfcr_pkg::SFCR_ADDR_ROUTING) mr[0] = d & sfcr_pkg::SFCR_MASK_ROUTING;
        if (n == 24 && a == sfcr_pkg::SFCR_ADDR_ACCURACY) mr[1] = d & sfcr_pkg::SFCR_MASK_ACCURACY;
        if (n == 24 && a == sfcr_pkg::SFCR_ADDR_CLOCK) mr[2] = d & sfcr_pkg::SFCR_MASK_CLOCK;
        host.tick(8);
        cmp();
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        shock_active = 1'b0;
        shock_level = 16'h0000;
        {crystal_select_pin, track_gain_up2, lock_int, cross_count_int, mirror_int, defect_int} = 6'h00;
        {focus_ok_int, lock_pin_i, cross_count_pin_i, mirror_pin_i, defect_pin_i} = 5'h00;
        {focus_ok_pin_i, shock_pin_i} = 2'b00;
        mr = '{default: 16'h0000};
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        host.tick(4);
        cmp();
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            wr(sfcr_pkg::SFCR_ADDR_ACCURACY, 16'(i[0]), 24);
            wr(sfcr_pkg::SFCR_ADDR_CLOCK, {2'b00, i[2:1], 12'h000}, 24);
        end
        $display("clock division done");
        wr(sfcr_pkg::SFCR_ADDR_ROUTING, 16'hffff, 23);
        wr(8'h3c, 16'hffff, 24);
        $display("refused words done");
        for (int i = 0; i < 30; i++) begin
            seed = lfsr(seed);
            wr(8'h3c + 8'(seed[1:0]), seed[31:16], 24);
        end
        $display("random words done");
        wr(sfcr_pkg::SFCR_ADDR_CLOCK, 16'h0050, 24);
        shock_active <= 1'b1;
        shock_level <= 16'h1000;
        host.tick(2 * sfcr_pkg::SFCR_FAST_CYC + 10);
        chk("shock high", 16'({shock_detected, shock_pin_o, misc.force_gain_normal}), 16'h0007);
        shock_level <= 16'h0400;
        host.tick(2 * sfcr_pkg::SFCR_FAST_CYC + 10);
        chk("shock low", 16'({shock_detected, shock_pin_o, misc.force_gain_normal}), 16'h0000);
        shock_active <= 1'b0;
        $display("shock done");
        rst <= 1'b1;
        host.tick(3);
        rst <= 1'b0;
        mr = '{default: 16'h0000};
        host.tick(4);
        cmp();
        $display("second reset done");
        host.tick(2 * sfcr_pkg::SFCR_SLOW_CYC + 10);
        chk("fast period", 16'(fper), 16'(sfcr_pkg::SFCR_FAST_CYC));
        chk("slow period", 16'(sper), 16'(sfcr_pkg::SFCR_SLOW_CYC));
        $display("sample rates done");
        stop_test();
    end
    // hang guard, beyond the expected run of some 75000 cycles
    initial begin
        #9500000;
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
